// ### src/nvap_top.sv
`default_nettype none
module nvap_top
   import nvap_pkg::*;
#(
   parameter int WRITE_RC_COUNT = nvap_pkg::WRITE_RC_CYCLES,
   parameter int RC_CNT_W = 16
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic cpu_rst,
   // cpu i/o register bus
   input wire logic [7:0] io_addr,
   input wire logic io_data_space,
   input wire logic io_we,
   input wire logic io_re,
   input wire logic io_bit_set,
   input wire logic io_bit_clr,
   input wire logic [2:0] io_bit_idx,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   output logic io_bit_test,
   output logic cpu_stall,
   // system status
   input wire logic cpu_irq_enable,
   input wire logic flash_program_busy,
   input wire logic power_down,
   input wire logic rc_tick,
   output logic nv_ready_irq,
   output logic rc_clk_request,
   // nonvolatile array port
   output logic [8:0] mem_addr,
   output logic [7:0] mem_wdata,
   output logic mem_we,
   output logic mem_re,
   input wire logic [7:0] mem_rdata
);
   import nvap_pkg::*;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   logic [7:0] io_ofs;
   logic hit;
   logic bit_ok;
   always_comb begin
      io_ofs = 8'h00;
      hit = 1'b0;
      if (!io_data_space) begin
         if (io_addr <= IO_TOP) begin
            io_ofs = io_addr;
            hit = 1'b1;
         end
      end else if (io_addr >= DSPACE_OFS && io_addr <= DSPACE_IO_TOP) begin
         io_ofs = io_addr - DSPACE_OFS;
         hit = 1'b1;
      end else if (io_addr >= EXT_LO) begin
         // extended space holds nothing of this block, reads zero
         hit = 1'b0;
      end
   end
   // bit ops exist only on the in/out path and the low 32 offsets
   assign bit_ok = !io_data_space && io_addr <= BITOP_TOP;

   // ----------------------------------------------------------------
   // write mask and value
   // ----------------------------------------------------------------
   logic [7:0] wmask;
   logic [7:0] wval;
   logic wr_any;
   always_comb begin
      wmask = 8'h00;
      wval = 8'h00;
      if (io_we) begin
         wmask = 8'hff;
         wval = io_wdata;
      end else if ((io_bit_set || io_bit_clr) && bit_ok) begin
         wmask = 8'h01 << io_bit_idx;
         wval = io_bit_set ? 8'hff : 8'h00;
      end
   end
   assign wr_any = ce && hit && (wmask != 8'h00);

   function automatic logic [7:0] merge(input logic [7:0] old);
      merge = (old & ~wmask) | (wval & wmask);
   endfunction

   logic wr_gps0, wr_gps1, wr_gps2, wr_ctrl, wr_data;
   logic wr_addrl, wr_addrh, wr_status;
   assign wr_gps0 = wr_any && io_ofs == OFS_GPS0;
   assign wr_gps1 = wr_any && io_ofs == OFS_GPS1;
   assign wr_gps2 = wr_any && io_ofs == OFS_GPS2;
   assign wr_ctrl = wr_any && io_ofs == OFS_CTRL;
   assign wr_data = wr_any && io_ofs == OFS_DATA;
   assign wr_addrl = wr_any && io_ofs == OFS_ADDRL;
   assign wr_addrh = wr_any && io_ofs == OFS_ADDRH;
   assign wr_status = wr_any && io_ofs == OFS_STATUS;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   nvap_state_e state_ff;
   logic [7:0] gps0_ff, gps1_ff, gps2_ff;
   logic [8:0] byte_index_ff;
   logic [7:0] data_ff;
   logic arm_ff;
   logic [2:0] arm_cnt_ff;
   logic irq_en_ff;
   logic read_strobe_ff;
   logic done_ff;
   logic keep_clk_ff;
   logic [2:0] stall_cnt_ff;
   logic [RC_CNT_W-1:0] rc_cnt_ff;
   logic [7:0] rdata_ff;
   logic bit_test_ff;
   logic [8:0] mem_addr_ff;
   logic [7:0] mem_wdata_ff;
   logic mem_we_ff;
   logic mem_re_ff;

   logic writing;
   logic strobe_w;
   logic strobe_r;
   logic arm_w;
   logic wr_start;
   logic rd_start;
   logic wr_end;
   logic [7:0] ctrl_w, addrh_w;
   assign writing = state_ff == NVAP_WRITING;
   // written out: an assign calling merge() would miss wmask changes
   assign ctrl_w = ({4'h0, irq_en_ff, arm_ff, writing, 1'b0} & ~wmask) |
                   (wval & wmask);
   assign addrh_w = ({7'h00, byte_index_ff[8]} & ~wmask) | (wval & wmask);
   assign strobe_w = wr_ctrl && wmask[CTL_WRITE_STROBE] &&
                     wval[CTL_WRITE_STROBE];
   assign strobe_r = wr_ctrl && wmask[CTL_READ_STROBE] &&
                     wval[CTL_READ_STROBE];
   assign arm_w = wr_ctrl && wmask[CTL_WRITE_ARM] && wval[CTL_WRITE_ARM];
   // an unarmed strobe, a busy engine or flash programming drops it
   assign wr_start = strobe_w && arm_ff && !writing
                     && !flash_program_busy;
   assign rd_start = strobe_r && !writing && !wr_start;
   assign wr_end = ce && writing && rc_tick &&
                   rc_cnt_ff == RC_CNT_W'(WRITE_RC_COUNT - 1);

   // ----------------------------------------------------------------
   // general storage
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         gps0_ff <= RST_GPS;
         gps1_ff <= RST_GPS;
         gps2_ff <= RST_GPS;
      end else if (ce && cpu_rst) begin
         gps0_ff <= RST_GPS;
      end else begin
         if (wr_gps0) gps0_ff <= merge(gps0_ff);
         if (wr_gps1) gps1_ff <= merge(gps1_ff);
         if (wr_gps2) gps2_ff <= merge(gps2_ff);
      end
   end

   // ----------------------------------------------------------------
   // index and data registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         byte_index_ff <= RST_INDEX;
      end else if (!writing) begin
         if (wr_addrl) byte_index_ff[7:0] <= merge(byte_index_ff[7:0]);
         if (wr_addrh) byte_index_ff[8] <= addrh_w[ADDRH_BIT8];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         data_ff <= RST_DATA;
      end else if (ce && mem_re_ff) begin
         data_ff <= mem_rdata;
      end else if (wr_data) begin
         data_ff <= merge(data_ff);
      end
   end

   // ----------------------------------------------------------------
   // control bits
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         arm_ff <= 1'b0;
         arm_cnt_ff <= 3'h0;
         irq_en_ff <= 1'b0;
      end else if (ce) begin
         if (cpu_rst) begin
            arm_ff <= 1'b0;
            arm_cnt_ff <= 3'h0;
            irq_en_ff <= 1'b0;
         end else begin
            if (wr_ctrl) irq_en_ff <= ctrl_w[CTL_READY_IRQ_EN];
            if (arm_w) begin
               arm_ff <= 1'b1;
               arm_cnt_ff <= ARM_CYCLES;
            end else if (arm_cnt_ff != 3'h0) begin
               arm_cnt_ff <= arm_cnt_ff - 3'h1;
               if (arm_cnt_ff == 3'h1) arm_ff <= 1'b0;
            end
         end
      end
   end

   // one-shot: high only in the cycle after the trigger
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         read_strobe_ff <= 1'b0;
      end else if (ce) begin
         read_strobe_ff <= rd_start && !cpu_rst;
      end
   end

   // ----------------------------------------------------------------
   // write engine, kept going over cpu reset and power-down
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= NVAP_IDLE;
         rc_cnt_ff <= '0;
      end else if (ce) begin
         case (state_ff)
            NVAP_IDLE: begin
               rc_cnt_ff <= '0;
               if (wr_start && !cpu_rst) state_ff <= NVAP_WRITING;
            end
            NVAP_WRITING: begin
               // no cpu_rst term here, so a cpu reset never aborts it; only rst_b does
               if (wr_end) begin
                  state_ff <= NVAP_IDLE;
               end else if (rc_tick) begin
                  rc_cnt_ff <= rc_cnt_ff + RC_CNT_W'(1);
               end
            end
            default: state_ff <= NVAP_IDLE;
         endcase
      end
   end

   // completion flag; a new completion beats a same-cycle clear
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         done_ff <= 1'b0;
      end else if (wr_end) begin
         done_ff <= 1'b1;
      end else if (ce && cpu_rst) begin
         done_ff <= 1'b0;
      end else if (wr_status && wmask[STS_WRITE_DONE] &&
                   wval[STS_WRITE_DONE]) begin
         done_ff <= 1'b0;
      end
   end

   // the oscillator stays requested once a write ends in power-down
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         keep_clk_ff <= 1'b0;
      end else if (ce) begin
         if (!power_down) keep_clk_ff <= 1'b0;
         else if (wr_end) keep_clk_ff <= 1'b1;
      end
   end
   assign rc_clk_request = writing || keep_clk_ff;

   // ----------------------------------------------------------------
   // array port
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mem_addr_ff <= RST_INDEX;
         mem_wdata_ff <= RST_DATA;
         mem_we_ff <= 1'b0;
         mem_re_ff <= 1'b0;
      end else if (ce) begin
         mem_we_ff <= wr_start && !cpu_rst;
         mem_re_ff <= rd_start && !cpu_rst;
         if (wr_start || rd_start) mem_addr_ff <= byte_index_ff;
         if (wr_start) mem_wdata_ff <= data_ff;
      end
   end
   assign mem_addr = mem_addr_ff;
   assign mem_wdata = mem_wdata_ff;
   assign mem_we = mem_we_ff;
   assign mem_re = mem_re_ff;

   // ----------------------------------------------------------------
   // cpu stall
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stall_cnt_ff <= 3'h0;
      end else if (ce) begin
         if (rd_start) stall_cnt_ff <= READ_STALL_CYCLES;
         else if (wr_start) stall_cnt_ff <= WRITE_STALL_CYCLES;
         else if (stall_cnt_ff != 3'h0) stall_cnt_ff <= stall_cnt_ff - 3'h1;
      end
   end
   assign cpu_stall = stall_cnt_ff != 3'h0;

   assign nv_ready_irq = irq_en_ff && cpu_irq_enable && !writing;

   // ----------------------------------------------------------------
   // read mux, registered
   // ----------------------------------------------------------------
   logic [7:0] rmux;
   always_comb begin
      rmux = 8'h00;
      if (!hit) rmux = 8'h00;
      else if (io_ofs == OFS_GPS0) rmux = gps0_ff;
      else if (io_ofs == OFS_GPS1) rmux = gps1_ff;
      else if (io_ofs == OFS_GPS2) rmux = gps2_ff;
      else if (io_ofs == OFS_DATA) rmux = data_ff;
      else if (io_ofs == OFS_ADDRL) rmux = byte_index_ff[7:0];
      else if (io_ofs == OFS_ADDRH) rmux = {7'h00, byte_index_ff[8]};
      else if (io_ofs == OFS_STATUS) rmux = {7'h00, done_ff};
      else if (io_ofs == OFS_CTRL) begin
         rmux = {4'h0, irq_en_ff, arm_ff, writing, read_strobe_ff};
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_ff <= 8'h00;
         bit_test_ff <= 1'b0;
      end else if (ce && io_re) begin
         rdata_ff <= rmux;
         bit_test_ff <= bit_ok && rmux[io_bit_idx];
      end
   end
   assign io_rdata = rdata_ff;
   assign io_bit_test = bit_test_ff;
endmodule : nvap_top
`default_nettype wire

// ### src/nvap_pkg.sv
`default_nettype none
package nvap_pkg;
   // -----------------------------------------------------------------
   // register offsets, i/o space numbering
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_STATUS = 8'h1d;
   localparam logic [7:0] OFS_GPS0 = 8'h1e;
   localparam logic [7:0] OFS_CTRL = 8'h1f;
   localparam logic [7:0] OFS_DATA = 8'h20;
   localparam logic [7:0] OFS_ADDRL = 8'h21;
   localparam logic [7:0] OFS_ADDRH = 8'h22;
   localparam logic [7:0] OFS_GPS1 = 8'h2a;
   localparam logic [7:0] OFS_GPS2 = 8'h2b;
   // -----------------------------------------------------------------
   // address spaces
   // -----------------------------------------------------------------
   localparam logic [7:0] IO_TOP = 8'h3f;
   localparam logic [7:0] BITOP_TOP = 8'h1f;
   localparam logic [7:0] DSPACE_OFS = 8'h20;
   localparam logic [7:0] DSPACE_IO_TOP = 8'h5f;
   localparam logic [7:0] EXT_LO = 8'h60;
   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int CTL_READ_STROBE = 0;
   localparam int CTL_WRITE_STROBE = 1;
   localparam int CTL_WRITE_ARM = 2;
   localparam int CTL_READY_IRQ_EN = 3;
   localparam int STS_WRITE_DONE = 0;
   localparam int ADDRH_BIT8 = 0;
   // -----------------------------------------------------------------
   // reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] RST_GPS = 8'h00;
   localparam logic [8:0] RST_INDEX = 9'h000;
   localparam logic [7:0] RST_DATA = 8'h00;
   // -----------------------------------------------------------------
   // timing counts, in cpu clock cycles or rc oscillator cycles
   // -----------------------------------------------------------------
   localparam logic [2:0] ARM_CYCLES = 3'h4;
   localparam logic [2:0] READ_STALL_CYCLES = 3'h4;
   localparam logic [2:0] WRITE_STALL_CYCLES = 3'h2;
   localparam int WRITE_RC_CYCLES = 27072;
   typedef enum logic {NVAP_IDLE, NVAP_WRITING} nvap_state_e;
endpackage : nvap_pkg
`default_nettype wire

// ### src/nvap_unused_guard.sv
`default_nettype none
`default_nettype wire

// ### tb/nvap_props.sv
`default_nettype none
module nvap_props
   import nvap_pkg::*;
#(
   parameter int WRITE_RC_COUNT = 5,
   parameter int RC_CNT_W = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic cpu_rst,
   // cpu bus
   input wire logic [7:0] io_addr,
   input wire logic io_data_space,
   input wire logic io_we,
   input wire logic io_re,
   input wire logic io_bit_set,
   input wire logic io_bit_clr,
   input wire logic [2:0] io_bit_idx,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   input wire logic io_bit_test,
   input wire logic cpu_stall,
   // system
   input wire logic cpu_irq_enable,
   input wire logic flash_program_busy,
   input wire logic power_down,
   input wire logic rc_tick,
   input wire logic nv_ready_irq,
   input wire logic rc_clk_request,
   // array port
   input wire logic [8:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   input wire logic mem_we,
   input wire logic mem_re,
   input wire logic [7:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic ctl_hit;
   logic [7:0] ctl_bits;
   logic arm_req, wstb, rstb, p_writing, busy_ff;
   logic [2:0] arm_cnt_ff;
   int tick_cnt_ff;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   assign ctl_hit = io_data_space ? (io_addr == OFS_CTRL + DSPACE_OFS)
                                  : (io_addr == OFS_CTRL);
   // control bits raised by a byte write or a bit set; the byte write
   // wins and bit ops exist only on the in/out path
   assign ctl_bits = (!ce || !ctl_hit) ? 8'h00 : io_we ? io_wdata :
                     (io_bit_set && !io_data_space) ? 8'h01 << io_bit_idx :
                     8'h00;
   assign arm_req = ctl_bits[CTL_WRITE_ARM];
   assign wstb = ctl_bits[CTL_WRITE_STROBE];
   assign rstb = ctl_bits[CTL_READ_STROBE];
   assign p_writing = mem_we || busy_ff;
   // arm window seen from the bus; opens on an arm write, lasts four edges
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         arm_cnt_ff <= 3'h0;
      end else if (ce && cpu_rst) begin
         arm_cnt_ff <= 3'h0;
      end else if (arm_req) begin
         arm_cnt_ff <= ARM_CYCLES;
      end else if (ce && arm_cnt_ff != 3'h0) begin
         arm_cnt_ff <= arm_cnt_ff - 3'h1;
      end
   end
   // write in progress, rebuilt from the start pulse and the rc ticks;
   // the clock request alone also stays up after a write in sleep
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_ff <= 1'b0;
         tick_cnt_ff <= 0;
      end else if (ce) begin
         if (p_writing && rc_tick) begin
            if (tick_cnt_ff == WRITE_RC_COUNT - 1) begin
               busy_ff <= 1'b0;
               tick_cnt_ff <= 0;
            end else begin
               busy_ff <= 1'b1;
               tick_cnt_ff <= tick_cnt_ff + 1;
            end
         end else if (mem_we) begin
            busy_ff <= 1'b1;
         end
      end
   end
   AST_WRITE_CAUSE: assert property (mem_we |->
      $past(wstb && arm_cnt_ff != 3'h0)) else $error("write without arm");
   AST_WRITE_START: assert property (
      $past(wstb && arm_cnt_ff != 3'h0 && !flash_program_busy && !cpu_rst
      && !p_writing) |-> mem_we) else $error("armed strobe did not write");
   AST_FLASH_BLOCK: assert property (
      mem_we |-> !$past(flash_program_busy))
      else $error("write during flash programming");
   AST_READ_START: assert property (
      $past(rstb && !wstb && !cpu_rst && !p_writing) |-> mem_re)
      else $error("read strobe not issued");
   AST_NO_READ_BUSY: assert property (mem_re |-> !$past(p_writing))
      else $error("read while writing");
   AST_READ_STALL: assert property (
      mem_re |-> cpu_stall [*4] ##1 !cpu_stall)
      else $error("read stall length wrong");
   AST_WRITE_STALL: assert property (
      mem_we |-> cpu_stall [*2] ##1 !cpu_stall)
      else $error("write stall length wrong");
   AST_WRITE_BUSY: assert property (
      mem_we |-> rc_clk_request && !nv_ready_irq)
      else $error("write not busy");
   AST_IRQ_GATE: assert property (nv_ready_irq |-> cpu_irq_enable)
      else $error("irq without global enable");
   AST_CTRL_RSVD: assert property ($past(io_re && ctl_hit) |->
      io_rdata[7:4] == 4'h0) else $error("reserved control bits set");
   cover property (mem_we);
   cover property (mem_re);
   cover property (nv_ready_irq);
endmodule // nvap_props
bind nvap_top nvap_props #(.WRITE_RC_COUNT(WRITE_RC_COUNT),
   .RC_CNT_W(RC_CNT_W)) u_props (.clk(clk), .rst_b(rst_b), .ce(ce),
   .cpu_rst(cpu_rst), .io_addr(io_addr), .io_data_space(io_data_space),
   .io_we(io_we), .io_re(io_re), .io_bit_set(io_bit_set),
   .io_bit_clr(io_bit_clr), .io_bit_idx(io_bit_idx), .io_wdata(io_wdata),
   .io_rdata(io_rdata), .io_bit_test(io_bit_test), .cpu_stall(cpu_stall),
   .cpu_irq_enable(cpu_irq_enable), .flash_program_busy(flash_program_busy),
   .power_down(power_down), .rc_tick(rc_tick), .nv_ready_irq(nv_ready_irq),
   .rc_clk_request(rc_clk_request), .mem_addr(mem_addr),
   .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re),
   .mem_rdata(mem_rdata));
`default_nettype wire

// ### tb/nvap_mem_model.sv
`default_nettype none
module nvap_mem_model (
   // clock
   input wire logic clk,
   // array port
   input wire logic [8:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   input wire logic mem_we,
   input wire logic mem_re,
   output logic [7:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cell_ff [512];
   logic [7:0] last_ff;
   initial begin
      for (int i = 0; i < 512; i++) begin
         cell_ff[i] = 8'(i) ^ 8'h5a;
      end
      last_ff = 8'h00;
   end
   always @(posedge clk) begin
      if (mem_we) begin
         cell_ff[mem_addr] <= mem_wdata;
      end
      // port floats outside a read; keep it moving so stale data shows
      last_ff <= mem_re ? cell_ff[mem_addr] : ~last_ff;
   end
   assign mem_rdata = mem_re ? cell_ff[mem_addr] : ~last_ff;
endmodule // nvap_mem_model
`default_nettype wire

// ### tb/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import nvap_pkg::*;
   logic clk, rst_b, ce, cpu_rst, io_data_space, io_we, io_re, io_bit_set;
   logic io_bit_clr, io_bit_test, cpu_stall, cpu_irq_enable, rc_tick;
   logic flash_program_busy, power_down, nv_ready_irq, rc_clk_request;
   logic mem_we, mem_re;
   logic [2:0] io_bit_idx;
   logic [7:0] io_addr, io_wdata, io_rdata, mem_wdata, mem_rdata, v;
   logic [8:0] mem_addr;
   int errors = 0;
   int checked = 0;
   nvap_top #(.WRITE_RC_COUNT(5), .RC_CNT_W(16)) uut (.clk(clk),
      .rst_b(rst_b), .ce(ce), .cpu_rst(cpu_rst), .io_addr(io_addr),
      .io_data_space(io_data_space), .io_we(io_we), .io_re(io_re),
      .io_bit_set(io_bit_set), .io_bit_clr(io_bit_clr),
      .io_bit_idx(io_bit_idx), .io_wdata(io_wdata), .io_rdata(io_rdata),
      .io_bit_test(io_bit_test), .cpu_stall(cpu_stall),
      .cpu_irq_enable(cpu_irq_enable), .flash_program_busy(flash_program_busy),
      .power_down(power_down), .rc_tick(rc_tick), .nv_ready_irq(nv_ready_irq),
      .rc_clk_request(rc_clk_request), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re),
      .mem_rdata(mem_rdata));
   nvap_mem_model u_mem (.clk(clk), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re),
      .mem_rdata(mem_rdata));
   // ----------------------------------------------------------------
   // bus tasks
   // ----------------------------------------------------------------
   task automatic chk8(input logic [7:0] g, input logic [7:0] e, string m);
      checked++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic chkb(input logic g, input logic e, string m);
      checked++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %0t %s got %b exp %b", $time, m, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic d, input logic [7:0] x);
      @(negedge clk);
      io_addr = a;
      io_data_space = d;
      io_wdata = x;
      io_we = 1'b1;
      @(negedge clk);
      io_we = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic d);
      @(negedge clk);
      io_addr = a;
      io_data_space = d;
      io_re = 1'b1;
      @(negedge clk);
      io_re = 1'b0;
      v = io_rdata;
   endtask
   task automatic bop(input logic s, input logic [7:0] a, input logic [2:0] i);
      @(negedge clk);
      io_addr = a;
      io_data_space = 1'b0;
      io_bit_idx = i;
      io_bit_set = s;
      io_bit_clr = !s;
      @(negedge clk);
      io_bit_set = 1'b0;
      io_bit_clr = 1'b0;
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         @(negedge clk);
         rc_tick = 1'b1;
         @(negedge clk);
         rc_tick = 1'b0;
      end
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_regs;
      rd(OFS_GPS0, 1'b0);
      chk8(v, 8'h00, "gps0 reset");
      wr(OFS_GPS0 + DSPACE_OFS, 1'b1, 8'ha5);
      rd(OFS_GPS0, 1'b0);
      chk8(v, 8'ha5, "gps0 via data space");
      wr(OFS_GPS1, 1'b0, 8'h3c);
      wr(OFS_GPS2, 1'b0, 8'hc3);
      rd(OFS_GPS2, 1'b0);
      chk8(v, 8'hc3, "gps2");
      bop(1'b1, OFS_GPS0, 3'h6);
      bop(1'b0, OFS_GPS0, 3'h0);
      bop(1'b1, OFS_GPS1, 3'h0);
      bop(1'b1, OFS_GPS0, 3'h3);
      rd(OFS_GPS0, 1'b0);
      chk8(v, 8'hec, "gps0 bit ops");
      chkb(io_bit_test, 1'b1, "bit test");
      rd(OFS_GPS1, 1'b0);
      chk8(v, 8'h3c, "bit op above range");
      chkb(io_bit_test, 1'b0, "bit test above range");
      wr(OFS_ADDRH, 1'b0, 8'hff);
      rd(OFS_ADDRH, 1'b0);
      chk8(v, 8'h01, "index high reserved");
      rd(8'h7e, 1'b1);
      chk8(v, 8'h00, "extended space");
      $display("test regs done");
   endtask
   task automatic t_write;
      cpu_irq_enable = 1'b1;
      wr(OFS_ADDRL, 1'b0, 8'hff);
      wr(OFS_DATA, 1'b0, 8'h3c);
      wr(OFS_CTRL, 1'b0, 8'h08);
      chkb(nv_ready_irq, 1'b1, "irq idle");
      wr(OFS_CTRL, 1'b0, 8'h0c);
      wr(OFS_CTRL, 1'b0, 8'h0a);
      chkb(mem_we, 1'b1, "write start");
      chk8(mem_addr[7:0], 8'hff, "addr low");
      chkb(mem_addr[8], 1'b1, "addr bit8");
      chk8(mem_wdata, 8'h3c, "write data");
      chkb(cpu_stall, 1'b1, "write stall");
      chkb(nv_ready_irq, 1'b0, "irq busy");
      rd(OFS_CTRL, 1'b0);
      chkb(v[1], 1'b1, "busy");
      ticks(4);
      chkb(rc_clk_request, 1'b1, "still writing");
      ticks(1);
      @(negedge clk);
      chkb(rc_clk_request, 1'b0, "write done");
      chkb(nv_ready_irq, 1'b1, "irq ready");
      wr(OFS_STATUS, 1'b0, 8'h00);
      rd(OFS_STATUS, 1'b0);
      chkb(v[0], 1'b1, "done kept");
      wr(OFS_STATUS, 1'b0, 8'h01);
      rd(OFS_STATUS, 1'b0);
      chkb(v[0], 1'b0, "done cleared");
      wr(OFS_CTRL, 1'b0, 8'h01);
      chkb(mem_re, 1'b1, "read start");
      rd(OFS_DATA, 1'b0);
      chk8(v, 8'h3c, "read back");
      rd(OFS_CTRL, 1'b0);
      chk8(v, 8'h00, "read strobe clear");
      $display("test write done");
   endtask
   task automatic t_refuse;
      wr(OFS_CTRL, 1'b0, 8'h02);
      chkb(mem_we | cpu_stall, 1'b0, "unarmed strobe");
      wr(OFS_CTRL, 1'b0, 8'h04);
      repeat (4) @(negedge clk);
      wr(OFS_CTRL, 1'b0, 8'h02);
      chkb(mem_we, 1'b0, "arm expired");
      flash_program_busy = 1'b1;
      wr(OFS_CTRL, 1'b0, 8'h04);
      wr(OFS_CTRL, 1'b0, 8'h02);
      chkb(mem_we, 1'b0, "flash busy");
      flash_program_busy = 1'b0;
      $display("test refuse done");
   endtask
   task automatic t_busy;
      wr(OFS_ADDRL, 1'b0, 8'h10);
      wr(OFS_ADDRH, 1'b0, 8'h00);
      wr(OFS_DATA, 1'b0, 8'h77);
      bop(1'b1, OFS_CTRL, 3'h2);
      bop(1'b1, OFS_CTRL, 3'h1);
      chkb(mem_we, 1'b1, "second write");
      wr(OFS_ADDRL, 1'b0, 8'h20);
      wr(OFS_CTRL, 1'b0, 8'h01);
      chkb(mem_re, 1'b0, "read while busy");
      @(negedge clk);
      cpu_rst = 1'b1;
      @(negedge clk);
      cpu_rst = 1'b0;
      chkb(rc_clk_request, 1'b1, "reset keeps write");
      power_down = 1'b1;
      ticks(5);
      rd(OFS_CTRL, 1'b0);
      chkb(v[1], 1'b0, "write ended in sleep");
      chkb(rc_clk_request, 1'b1, "clock kept in sleep");
      power_down = 1'b0;
      repeat (2) @(negedge clk);
      chkb(rc_clk_request, 1'b0, "clock released");
      rd(OFS_ADDRL, 1'b0);
      chk8(v, 8'h10, "index held");
      wr(OFS_CTRL, 1'b0, 8'h01);
      rd(OFS_DATA, 1'b0);
      chk8(v, 8'h77, "write survived reset");
      $display("test busy done");
   endtask
   task automatic conclude;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      {rst_b, cpu_rst, io_data_space, io_we, io_re, io_bit_set} = '0;
      {io_bit_clr, cpu_irq_enable, rc_tick, flash_program_busy} = '0;
      {power_down, io_bit_idx, io_addr, io_wdata} = '0;
      ce = 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst_b = 1'b1;
      t_regs();
      t_write();
      t_refuse();
      t_busy();
      conclude();
   end
   initial begin
      repeat (3000) @(posedge clk);
      errors++;
      conclude();
   end
endmodule // tb
`default_nettype wire
